// ===== inc/ptm_pkg.sv
`default_nettype none
package ptm_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SPEED_W = 20;
  localparam int POS_W = 32;
  localparam int CODE_W = 7;
  localparam int NET_N = 16;
  localparam int ECHO_N = 64;
  localparam int KEY_N = 5;
  localparam int IO_IN_N = 8;
  localparam int IO_OUT_N = 6;
  localparam int MOTION_N = 13;
  localparam int AUX_N = 6;
  localparam int EVT_N = 4;
  localparam int DATA_NUM_W = 8;
  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_JOG_SPEED = 8'h04;
  localparam logic [ADDR_W-1:0] REG_JOG_START = 8'h08;
  localparam logic [ADDR_W-1:0] REG_HOME_SPEED = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_PRESET_POS = 8'h10;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] REG_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_CMD_POS = 8'h20;
  localparam logic [ADDR_W-1:0] REG_OUT_CODE_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] REG_IN_CODE_BASE = 8'h80;
  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int CTRL_EDIT_LOCK = 0;
  localparam int CTRL_TEST_REQ = 1;
  localparam int EVT_ERROR_SHOWN = 0;
  localparam int EVT_CODE_REJECT = 1;
  localparam int EVT_TEACH_DONE = 2;
  localparam int EVT_PRESET_DONE = 3;
  localparam int KEY_UP = 0;
  localparam int KEY_DOWN = 1;
  localparam int KEY_LEFT = 2;
  localparam int KEY_SELECT = 3;
  localparam int KEY_ESCAPE = 4;
  localparam logic [SPEED_W-1:0] JOG_SPEED_RST = 20'h0_03E8;
  localparam logic [SPEED_W-1:0] JOG_START_RST = 20'h0_01F4;
  localparam logic [SPEED_W-1:0] HOME_SPEED_RST = 20'h0_03E8;
  localparam logic [EVT_N-1:0] MASK_RST = 4'h0;
  // ****************************************************************
  // Function codes
  // ****************************************************************
  localparam logic [CODE_W-1:0] FN_NONE = 7'h00;
  localparam logic [CODE_W-1:0] FN_IN_ALARM_CLEAR = 7'h18;
  localparam logic [CODE_W-1:0] FN_IN_PRESET = 7'h19;
  localparam logic [CODE_W-1:0] FN_IN_POS_CLEAR = 7'h1A;
  localparam logic [CODE_W-1:0] FN_ECHO_LIMIT = 7'h40;
  localparam logic [CODE_W-1:0] FN_ALARM = 7'h41;
  localparam logic [CODE_W-1:0] FN_WARNING = 7'h42;
  localparam logic [CODE_W-1:0] FN_READY = 7'h43;
  localparam logic [CODE_W-1:0] FN_MOVING = 7'h44;
  localparam logic [CODE_W-1:0] FN_POS_DONE = 7'h45;
  localparam logic [CODE_W-1:0] FN_AUX_BASE = 7'h46;
  localparam logic [CODE_W-1:0] FN_INTERNAL_BUSY = 7'h50;
  localparam logic [CODE_W-1:0] FN_MAIN_POWER = 7'h52;
  localparam logic [CODE_W-1:0] NETWORK_OUTPUT_RST [NET_N] = '{7'h30, 7'h31, 7'h32, 7'h04, 7'h46, 7'h43, 7'h42, 7'h41,
    7'h50, 7'h49, 7'h4A, 7'h4B, 7'h48, 7'h44, 7'h45, 7'h47};
  localparam logic [CODE_W-1:0] NETWORK_INPUT_RST [NET_N] = '{7'h30, 7'h31, 7'h32, 7'h04, 7'h03, 7'h12, 7'h10, 7'h00,
    7'h08, 7'h09, 7'h0A, 7'h05, 7'h06, 7'h07, 7'h01, 7'h02};
  // ****************************************************************
  // Display codes and timing
  // ****************************************************************
  localparam logic [2:0] DISP_NONE = 3'h0;
  localparam logic [2:0] DISP_OPERATION_ERR = 3'h1;
  localparam logic [2:0] DISP_MEM_BUSY = 3'h2;
  localparam logic [2:0] DISP_ERROR = 3'h3;
  localparam logic [2:0] DISP_LOCK_ERR = 3'h4;
  localparam int CLK_MHZ = 200;
  localparam int HOLD_MS = 500;
  localparam int HOLD_CYCLES = HOLD_MS * 1000 * CLK_MHZ;
  localparam int HOLD_W = 28;
  localparam logic [2:0] TOP_ITEMS = 3'h6;
  typedef enum logic [2:0] {
    PTM_OFF,
    PTM_TOP,
    PTM_IO_TEST,
    PTM_JOG,
    PTM_DATA_SEL,
    PTM_HOME,
    PTM_PRESET,
    PTM_TEACH
  } ptm_state_t;
endpackage : ptm_pkg
`default_nettype wire

// ===== hw/ptm_test_mode.sv
// Added by the designer: the placing of the registers and the strobed register port.
`default_nettype none
module ptm_test_mode #(
  parameter int HOLD_CYCLES = ptm_pkg::HOLD_CYCLES,
  parameter bit LATE_REVISION = 1'b1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input wire logic [ptm_pkg::ADDR_W-1:0] regAddr,
  input wire logic [ptm_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [ptm_pkg::DATA_W-1:0] regRdData,
  output logic irq,
  // Operator keypad and display
  input wire logic [ptm_pkg::KEY_N-1:0] keyPins,
  input wire logic operatorPermitInput,
  output logic [2:0] displayCode,
  output logic [ptm_pkg::IO_IN_N-1:0] displayInputDigits,
  output logic [ptm_pkg::IO_OUT_N-1:0] displayOutputDigits,
  output logic [2:0] displayCursor,
  output logic [ptm_pkg::DATA_NUM_W-1:0] displayDataNumber,
  output logic [2:0] testState,
  // Device status
  input wire logic motorRunning,
  input wire logic serialBusy,
  input wire logic alarmActive,
  input wire logic warningActive,
  input wire logic readyStatus,
  input wire logic posCompleteStatus,
  input wire logic mainPowerStatus,
  input wire logic [ptm_pkg::AUX_N-1:0] auxStatus,
  input wire logic [ptm_pkg::POS_W-1:0] reachedPosition,
  // Direct I/O
  input wire logic [ptm_pkg::IO_IN_N-1:0] ioInputPins,
  input wire logic [ptm_pkg::IO_OUT_N-1:0] ioOutputNormal,
  output logic [ptm_pkg::IO_OUT_N-1:0] ioOutputPins,
  output logic ioFunctionEnable,
  // Motion inputs toward the controller
  input wire logic [ptm_pkg::MOTION_N-1:0] motionInputs,
  output logic [ptm_pkg::MOTION_N-1:0] motionInputsGated,
  output logic motorEnable,
  // Test-mode motion commands
  output logic jogStepPos,
  output logic jogStepNeg,
  output logic jogRunPos,
  output logic jogRunNeg,
  output logic [ptm_pkg::SPEED_W-1:0] jogSpeed,
  output logic positionStart,
  output logic [ptm_pkg::DATA_NUM_W-1:0] positionDataNumber,
  output logic homeStart,
  output logic [ptm_pkg::SPEED_W-1:0] homeSpeed,
  output logic [ptm_pkg::POS_W-1:0] commandPosition,
  output logic teachWrite,
  output logic [ptm_pkg::DATA_NUM_W-1:0] teachDataNumber,
  output logic [ptm_pkg::POS_W-1:0] teachPosition,
  output logic teachAbsoluteMode,
  // Network inputs and outputs
  input wire logic [ptm_pkg::NET_N-1:0] networkInput,
  output logic [ptm_pkg::NET_N-1:0] networkOutput
);
  import ptm_pkg::*;

  if (HOLD_CYCLES < 2 || HOLD_CYCLES >= (1 << HOLD_W)) begin : gHoldCheck
    $error("HOLD_CYCLES out of range");
  end

  function automatic logic codeRejected(input logic [CODE_W-1:0] code);
    codeRejected = !LATE_REVISION && (code == FN_IN_ALARM_CLEAR || code == FN_IN_PRESET || code == FN_IN_POS_CLEAR);
  endfunction : codeRejected

  // ****************************************************************
  // Reset release and input synchronisers
  // ****************************************************************
  logic rstSync1_q, rstN;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      rstSync1_q <= 1'b0;
      rstN <= 1'b0;
    end
    else
    begin
      rstSync1_q <= 1'b1;
      rstN <= rstSync1_q;
    end

  logic [KEY_N-1:0] keySync1_q, keySync2_q, keyPrev_q, keyRise;
  logic permitSync1_q, permitSync2_q;
  logic [IO_IN_N-1:0] ioSync1_q, ioSync2_q;
  always_ff @(posedge clk_sys or negedge rstN)
    if (!rstN)
    begin
      keySync1_q <= '0;
      keySync2_q <= '0;
      keyPrev_q <= '0;
      permitSync1_q <= 1'b0;
      permitSync2_q <= 1'b0;
      ioSync1_q <= '0;
      ioSync2_q <= '0;
    end
    else
    begin
      keySync1_q <= keyPins;
      keySync2_q <= keySync1_q;
      keyPrev_q <= keySync2_q;
      permitSync1_q <= operatorPermitInput;
      permitSync2_q <= permitSync1_q;
      ioSync1_q <= ioInputPins;
      ioSync2_q <= ioSync1_q;
    end
  assign keyRise = keySync2_q & ~keyPrev_q;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic editLock_q, testReq_q;
  logic [SPEED_W-1:0] jogOpSpeed_q, jogStartSpeed_q, homeSpeed_q;
  logic [POS_W-1:0] presetPos_q;
  logic [EVT_N-1:0] status_q, mask_q, events;
  logic [CODE_W-1:0] outCode_q [NET_N];
  logic [CODE_W-1:0] inCode_q [NET_N];
  logic [3:0] regIndex;
  logic outCodeSel, inCodeSel, wrRejected;
  ptm_state_t state_q;
  assign regIndex = regAddr[5:2];
  assign outCodeSel = regAddr[7:6] == REG_OUT_CODE_BASE[7:6];
  assign inCodeSel = regAddr[7:6] == REG_IN_CODE_BASE[7:6];
  assign wrRejected = regWrite && inCodeSel && codeRejected(regWrData[CODE_W-1:0]);

  always_ff @(posedge clk_sys or negedge rstN)
    if (!rstN)
    begin
      editLock_q <= 1'b0;
      testReq_q <= 1'b0;
      jogOpSpeed_q <= JOG_SPEED_RST;
      jogStartSpeed_q <= JOG_START_RST;
      homeSpeed_q <= HOME_SPEED_RST;
      presetPos_q <= '0;
      mask_q <= MASK_RST;
    end
    else if (regWrite)
    begin
      case (regAddr)
        REG_CTRL:
        begin
          editLock_q <= regWrData[CTRL_EDIT_LOCK];
          testReq_q <= regWrData[CTRL_TEST_REQ];
        end
        REG_JOG_SPEED: jogOpSpeed_q <= regWrData[SPEED_W-1:0];
        REG_JOG_START: jogStartSpeed_q <= regWrData[SPEED_W-1:0];
        REG_HOME_SPEED: homeSpeed_q <= regWrData[SPEED_W-1:0];
        REG_PRESET_POS: presetPos_q <= regWrData;
        REG_MASK: mask_q <= regWrData[EVT_N-1:0];
        default: ;
      endcase
    end

  always_ff @(posedge clk_sys or negedge rstN)
    if (!rstN)
    begin
      for (int i = 0; i < NET_N; i++)
      begin
        outCode_q[i] <= NETWORK_OUTPUT_RST[i];
        inCode_q[i] <= NETWORK_INPUT_RST[i];
      end
    end
    else if (regWrite)
    begin
      if (outCodeSel)
        outCode_q[regIndex] <= regWrData[CODE_W-1:0];
      if (inCodeSel && !wrRejected)
        inCode_q[regIndex] <= regWrData[CODE_W-1:0];
    end

  // ****************************************************************
  // Test-mode sequencer
  // ****************************************************************
  logic [2:0] topItem_q, cursor_q, disp_q;
  logic [IO_OUT_N-1:0] testOut_q;
  logic [DATA_NUM_W-1:0] dataNum_q;
  logic lowerLevel, jogKeys, errShown, selectKey;
  logic [POS_W-1:0] cmdPos_q;
  logic posStart_q, homeStart_q, teachWr_q, presetDone;
  assign lowerLevel = state_q != PTM_OFF && state_q != PTM_TOP;
  assign jogKeys = state_q == PTM_JOG || state_q == PTM_TEACH;
  assign selectKey = keyRise[KEY_SELECT];
  assign errShown = selectKey && (state_q == PTM_TOP ? (motorRunning || serialBusy ||
    (editLock_q && (topItem_q == 3'h4 || topItem_q == 3'h5))) :
    (alarmActive && state_q != PTM_IO_TEST && state_q != PTM_JOG));
  assign presetDone = selectKey && state_q == PTM_PRESET && !alarmActive;

  always_ff @(posedge clk_sys or negedge rstN)
    if (!rstN)
    begin
      state_q <= PTM_OFF;
      topItem_q <= '0;
      disp_q <= DISP_NONE;
    end
    else if (!permitSync2_q || !testReq_q)
    begin
      state_q <= PTM_OFF;
      disp_q <= DISP_NONE;
    end
    else
    begin
      if (keyRise != '0)
        disp_q <= DISP_NONE;
      case (state_q)
        PTM_OFF: state_q <= PTM_TOP;
        PTM_TOP:
        begin
          if (keyRise[KEY_UP])
            topItem_q <= (topItem_q == TOP_ITEMS - 3'h1) ? 3'h0 : topItem_q + 3'h1;
          else if (keyRise[KEY_DOWN])
            topItem_q <= (topItem_q == 3'h0) ? TOP_ITEMS - 3'h1 : topItem_q - 3'h1;
          else if (selectKey)
          begin
            if (motorRunning)
              disp_q <= DISP_OPERATION_ERR;
            else if (serialBusy)
              disp_q <= DISP_MEM_BUSY;
            else if (editLock_q && (topItem_q == 3'h4 || topItem_q == 3'h5))
              disp_q <= DISP_LOCK_ERR;
            else
              state_q <= ptm_state_t'(topItem_q + 3'h2);
          end
        end
        PTM_IO_TEST, PTM_JOG, PTM_DATA_SEL, PTM_HOME, PTM_PRESET, PTM_TEACH:
        begin
          if (keyRise[KEY_ESCAPE])
            state_q <= PTM_TOP;
          else if (errShown)
            disp_q <= DISP_ERROR;
        end
        default: state_q <= PTM_OFF;
      endcase
    end

  // ****************************************************************
  // Direct I/O test and data number selection
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rstN)
    if (!rstN)
    begin
      cursor_q <= '0;
      testOut_q <= '0;
      dataNum_q <= '0;
    end
    else if (state_q == PTM_IO_TEST)
    begin
      if (keyRise[KEY_LEFT])
        cursor_q <= (cursor_q == 3'(IO_OUT_N - 1)) ? 3'h0 : cursor_q + 3'h1;
      if (keyRise[KEY_UP])
        testOut_q[cursor_q] <= 1'b1;
      else if (keyRise[KEY_DOWN])
        testOut_q[cursor_q] <= 1'b0;
    end
    else if (state_q == PTM_DATA_SEL || (state_q == PTM_TEACH && keyRise[KEY_LEFT]))
    begin
      if (state_q == PTM_TEACH || keyRise[KEY_UP])
        dataNum_q <= dataNum_q + 1'b1;
      else if (keyRise[KEY_DOWN])
        dataNum_q <= dataNum_q - 1'b1;
    end
    else if (state_q == PTM_TOP)
    begin
      testOut_q <= '0;
      cursor_q <= '0;
    end

  // ****************************************************************
  // Panel jog, shared by teaching
  // ****************************************************************
  logic [HOLD_W-1:0] holdCnt_q;
  logic stepPos_q, stepNeg_q, runPos_q, runNeg_q;
  logic holdUp, holdDown;
  assign holdUp = jogKeys && keySync2_q[KEY_UP] && !keySync2_q[KEY_DOWN];
  assign holdDown = jogKeys && keySync2_q[KEY_DOWN] && !keySync2_q[KEY_UP];

  always_ff @(posedge clk_sys or negedge rstN)
    if (!rstN)
    begin
      holdCnt_q <= '0;
      stepPos_q <= 1'b0;
      stepNeg_q <= 1'b0;
      runPos_q <= 1'b0;
      runNeg_q <= 1'b0;
    end
    else
    begin
      stepPos_q <= holdUp && keyRise[KEY_UP];
      stepNeg_q <= holdDown && keyRise[KEY_DOWN];
      if (!(holdUp || holdDown) || keyRise[KEY_UP] || keyRise[KEY_DOWN])
        holdCnt_q <= '0;
      else if (holdCnt_q != HOLD_W'(HOLD_CYCLES))
        holdCnt_q <= holdCnt_q + 1'b1;
      runPos_q <= holdUp && holdCnt_q == HOLD_W'(HOLD_CYCLES);
      runNeg_q <= holdDown && holdCnt_q == HOLD_W'(HOLD_CYCLES);
    end

  // ****************************************************************
  // Positioning, home, preset and teaching commands
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rstN)
    if (!rstN)
    begin
      posStart_q <= 1'b0;
      homeStart_q <= 1'b0;
      teachWr_q <= 1'b0;
      cmdPos_q <= '0;
      teachPosition <= '0;
    end
    else
    begin
      posStart_q <= selectKey && state_q == PTM_DATA_SEL && !alarmActive;
      homeStart_q <= selectKey && state_q == PTM_HOME && !alarmActive;
      teachWr_q <= selectKey && state_q == PTM_TEACH && !alarmActive && !editLock_q;
      if (presetDone && !editLock_q)
        cmdPos_q <= presetPos_q;
      if (selectKey && state_q == PTM_TEACH)
        teachPosition <= reachedPosition;
    end

  // ****************************************************************
  // Network output mapping
  // ****************************************************************
  logic [ECHO_N-1:0] inFuncState;
  logic [NET_N-1:0] netOut_d;
  always_comb
  begin
    inFuncState = '0;
    for (int i = 0; i < NET_N; i++)
      if (inCode_q[i] < FN_ECHO_LIMIT)
        inFuncState[inCode_q[i][5:0]] = inFuncState[inCode_q[i][5:0]] | networkInput[i];
    inFuncState[0] = 1'b0;
  end

  always_comb
  begin
    netOut_d = '0;
    for (int i = 0; i < NET_N; i++)
    begin
      if (outCode_q[i] == FN_NONE)
        netOut_d[i] = 1'b0;
      else if (outCode_q[i] < FN_ECHO_LIMIT)
        netOut_d[i] = inFuncState[outCode_q[i][5:0]];
      else if (outCode_q[i] == FN_ALARM)
        netOut_d[i] = alarmActive;
      else if (outCode_q[i] == FN_WARNING)
        netOut_d[i] = warningActive;
      else if (outCode_q[i] == FN_READY)
        netOut_d[i] = readyStatus;
      else if (outCode_q[i] == FN_MOVING)
        netOut_d[i] = motorRunning;
      else if (outCode_q[i] == FN_POS_DONE)
        netOut_d[i] = posCompleteStatus;
      else if (outCode_q[i] >= FN_AUX_BASE && outCode_q[i] < FN_AUX_BASE + 7'(AUX_N))
        netOut_d[i] = auxStatus[3'(outCode_q[i] - FN_AUX_BASE)];
      else if (outCode_q[i] == FN_INTERNAL_BUSY)
        netOut_d[i] = serialBusy;
      else if (outCode_q[i] == FN_MAIN_POWER)
        netOut_d[i] = mainPowerStatus;
    end
  end

  // ****************************************************************
  // Registered outputs, status and read-back
  // ****************************************************************
  assign events = {presetDone && !editLock_q, teachWr_q, wrRejected, errShown};
  always_ff @(posedge clk_sys or negedge rstN)
    if (!rstN)
      status_q <= '0;
    else
      status_q <= ((regRead && regAddr == REG_STATUS) ? '0 : status_q) | events;

  always_ff @(posedge clk_sys or negedge rstN)
    if (!rstN)
    begin
      regRdData <= '0;
      irq <= 1'b0;
    end
    else
    begin
      irq <= (status_q & mask_q) != '0;
      regRdData <= '0;
      if (regRead)
      begin
        if (outCodeSel)
          regRdData <= 32'(outCode_q[regIndex]);
        else if (inCodeSel)
          regRdData <= 32'(inCode_q[regIndex]);
        else
          case (regAddr)
            REG_CTRL: regRdData <= 32'({testReq_q, editLock_q});
            REG_JOG_SPEED: regRdData <= 32'(jogOpSpeed_q);
            REG_JOG_START: regRdData <= 32'(jogStartSpeed_q);
            REG_HOME_SPEED: regRdData <= 32'(homeSpeed_q);
            REG_PRESET_POS: regRdData <= presetPos_q;
            REG_STATUS: regRdData <= 32'(status_q);
            REG_MASK: regRdData <= 32'(mask_q);
            REG_STATE: regRdData <= 32'({disp_q, state_q});
            REG_CMD_POS: regRdData <= cmdPos_q;
            default: regRdData <= '0;
          endcase
      end
    end

  always_ff @(posedge clk_sys or negedge rstN)
    if (!rstN)
    begin
      displayCode <= DISP_NONE;
      displayInputDigits <= '0;
      displayOutputDigits <= '0;
      displayCursor <= '0;
      displayDataNumber <= '0;
      testState <= 3'h0;
      ioOutputPins <= '0;
      ioFunctionEnable <= 1'b0;
      motionInputsGated <= '0;
      motorEnable <= 1'b0;
      jogStepPos <= 1'b0;
      jogStepNeg <= 1'b0;
      jogRunPos <= 1'b0;
      jogRunNeg <= 1'b0;
      jogSpeed <= '0;
      positionStart <= 1'b0;
      positionDataNumber <= '0;
      homeStart <= 1'b0;
      homeSpeed <= '0;
      commandPosition <= '0;
      teachWrite <= 1'b0;
      teachDataNumber <= '0;
      teachAbsoluteMode <= 1'b0;
      networkOutput <= '0;
    end
    else
    begin
      displayCode <= disp_q;
      displayInputDigits <= (state_q == PTM_IO_TEST) ? ioSync2_q : '0;
      displayOutputDigits <= testOut_q;
      displayCursor <= cursor_q;
      displayDataNumber <= dataNum_q;
      testState <= state_q;
      ioOutputPins <= (state_q == PTM_IO_TEST) ? testOut_q : ioOutputNormal;
      ioFunctionEnable <= state_q != PTM_IO_TEST;
      motionInputsGated <= lowerLevel ? '0 : motionInputs;
      motorEnable <= state_q != PTM_IO_TEST;
      jogStepPos <= stepPos_q;
      jogStepNeg <= stepNeg_q;
      jogRunPos <= runPos_q;
      jogRunNeg <= runNeg_q;
      jogSpeed <= (jogStartSpeed_q > jogOpSpeed_q) ? jogStartSpeed_q : jogOpSpeed_q;
      positionStart <= posStart_q;
      positionDataNumber <= dataNum_q;
      homeStart <= homeStart_q;
      homeSpeed <= homeSpeed_q;
      commandPosition <= cmdPos_q;
      teachWrite <= teachWr_q;
      teachDataNumber <= dataNum_q;
      teachAbsoluteMode <= teachWr_q;
      networkOutput <= netOut_d;
    end
endmodule : ptm_test_mode
`default_nettype wire

// ===== sim/ptm_test_mode_assertions.sv
`default_nettype none
module ptm_test_mode_assertions (
  // Watched ports
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic operatorPermitInput,
  input wire logic alarmActive,
  input wire logic [ptm_pkg::IO_IN_N-1:0] ioInputPins,
  input wire logic [2:0] testState,
  input wire logic [ptm_pkg::MOTION_N-1:0] motionInputsGated,
  input wire logic motorEnable,
  input wire logic ioFunctionEnable,
  input wire logic [ptm_pkg::IO_IN_N-1:0] displayInputDigits,
  input wire logic [ptm_pkg::IO_OUT_N-1:0] displayOutputDigits,
  input wire logic [ptm_pkg::IO_OUT_N-1:0] ioOutputPins,
  input wire logic jogRunPos,
  input wire logic jogStepNeg,
  input wire logic positionStart,
  input wire logic homeStart
);
  timeunit 1ns;
  timeprecision 100ps;
  import ptm_pkg::*;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  property p_gate; testState > 3'h1 && $past(testState) > 3'h1 |-> motionInputsGated == '0; endproperty
  a_gate: assert property (p_gate) else $error("gate");
  property p_io; testState == PTM_IO_TEST && $past(testState) == PTM_IO_TEST |-> !motorEnable && !ioFunctionEnable;
  endproperty
  a_io: assert property (p_io) else $error("io");
  property p_permit; !operatorPermitInput [*5] |-> testState == PTM_OFF; endproperty
  a_permit: assert property (p_permit) else $error("permit");
  property p_dig; (testState == PTM_IO_TEST && $stable(ioInputPins)) [*4] |-> displayInputDigits == ioInputPins;
  endproperty
  a_dig: assert property (p_dig) else $error("digits");
  property p_out; testState == PTM_IO_TEST && $past(testState) == PTM_IO_TEST && $stable(displayOutputDigits)
    |-> ioOutputPins == displayOutputDigits; endproperty
  a_out: assert property (p_out) else $error("outputs");
  property p_run; $rose(jogRunPos) |-> $past(testState) == PTM_JOG || $past(testState) == PTM_TEACH; endproperty
  a_run: assert property (p_run) else $error("run");
  property p_step; jogStepNeg |=> !jogStepNeg; endproperty
  a_step: assert property (p_step) else $error("step");
  property p_alarm; $past(alarmActive, 2) |-> !(positionStart || homeStart); endproperty
  a_alarm: assert property (p_alarm) else $error("alarm");
endmodule : ptm_test_mode_assertions
bind ptm_test_mode ptm_test_mode_assertions i_ptm_test_mode_assertions (.*);
`default_nettype wire

// ===== sim/ptm_keypad.sv
`default_nettype none
module ptm_keypad (
  // Keypad lines
  input wire logic clk_sys,
  output logic [ptm_pkg::KEY_N-1:0] keyPins
);
  timeunit 1ns;
  timeprecision 100ps;
  initial keyPins = '0;
  task automatic press(input int c, input int n);
    @(posedge clk_sys) keyPins[c] <= 1'h1;
    repeat (n) @(posedge clk_sys);
    keyPins[c] <= 1'h0;
    repeat (8) @(posedge clk_sys);
  endtask : press
endmodule : ptm_keypad
`default_nettype wire

// ===== sim/panel_test_mode_and_io_mapping_test.sv
`default_nettype none
module panel_test_mode_and_io_mapping_test;
  timeunit 1ns;
  timeprecision 100ps;
  import ptm_pkg::*;
  logic clk_sys = '0, resetn = '0, regWrite = '0, regRead = '0, rdV = '0, operatorPermitInput = '0;
  logic motorRunning = '0, serialBusy = '0, alarmActive = '0, warningActive = '0, readyStatus = '0;
  logic posCompleteStatus = '0, mainPowerStatus = '0, irq, jogStepPos, jogStepNeg, jogRunPos, jogRunNeg;
  logic positionStart, homeStart, teachWrite, teachAbsoluteMode, ioFunctionEnable, motorEnable;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0, regRdData, s, q[$];
  logic [AUX_N-1:0] auxStatus = '0;
  logic [POS_W-1:0] reachedPosition = '0, commandPosition, teachPosition;
  logic [IO_IN_N-1:0] ioInputPins = '0, displayInputDigits;
  logic [IO_OUT_N-1:0] ioOutputNormal = '0, displayOutputDigits, ioOutputPins;
  logic [MOTION_N-1:0] motionInputs = '0, motionInputsGated;
  logic [NET_N-1:0] networkInput = '0, networkOutput;
  logic [KEY_N-1:0] keyPins;
  logic [2:0] displayCode, displayCursor, testState;
  logic [DATA_NUM_W-1:0] displayDataNumber, positionDataNumber, teachDataNumber;
  logic [SPEED_W-1:0] jogSpeed, homeSpeed;
  logic [CODE_W-1:0] codes [7] = '{FN_NONE, FN_ALARM, FN_WARNING, FN_READY, FN_MOVING, FN_POS_DONE, FN_INTERNAL_BUSY};
  int nErrors = 0, nChecks = 0, nNeg = 0, nStart = 0, nTeach = 0;
  always #2.5 clk_sys = ~clk_sys;
  ptm_test_mode #(.HOLD_CYCLES(20)) i_ptm_test_mode (.*);
  ptm_keypad i_ptm_keypad (.*);
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    nChecks++;
    if (g !== x)
    begin
      nErrors++;
      $display("ERROR %0t: got %h want %h", $time, g, x);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys) {regWrite, regAddr, regWrData} <= {1'h1, a, d};
    @(posedge clk_sys) regWrite <= 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    q.push_back(x);
    @(posedge clk_sys) {regRead, regAddr} <= {1'h1, a};
    @(posedge clk_sys) regRead <= 1'h0;
  endtask : rd
  task automatic k(input int c, input int n);
    i_ptm_keypad.press(c, n);
  endtask : k
  task automatic giveVerdict;
    $display("checks %0d errors %0d", nChecks, nErrors);
    if (nErrors == 0 && nChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : giveVerdict
  always @(posedge clk_sys)
  begin
    if (rdV)
      chk(regRdData, q.pop_front());
    rdV <= regRead;
    nNeg <= nNeg + jogStepNeg;
    nStart <= nStart + positionStart;
    nTeach <= nTeach + (teachWrite && teachAbsoluteMode);
  end
  initial
  begin
    #50us;
    nErrors++;
    giveVerdict();
  end
  initial
  begin
    s = $urandom(32'h3ac4);
    repeat (4) @(posedge clk_sys);
    resetn <= 1'h1;
    repeat (3) @(posedge clk_sys);
    {auxStatus, ioOutputNormal, motionInputs} <= 25'($urandom);
    rd(REG_HOME_SPEED, 32'(HOME_SPEED_RST));
    rd(8'hFC, 32'h0);
    wr(REG_JOG_START, 32'h1388);
    wr(REG_MASK, 32'h1);
    wr(REG_CTRL, 32'h2);
    {operatorPermitInput, motorRunning, ioInputPins} <= {2'h3, 8'($urandom)};
    k(KEY_SELECT, 2);
    chk(displayCode, DISP_OPERATION_ERR);
    chk(irq, 1'h1);
    rd(REG_STATUS, 32'h1);
    motorRunning <= 1'h0;
    k(KEY_SELECT, 2);
    chk(testState, PTM_IO_TEST);
    k(KEY_LEFT, 2);
    k(KEY_UP, 2);
    chk(ioOutputPins, 6'h2);
    chk(displayInputDigits, ioInputPins);
    $display("io test done");
    k(KEY_ESCAPE, 2);
    k(KEY_UP, 2);
    k(KEY_SELECT, 2);
    chk(jogSpeed, 32'h1388);
    k(KEY_DOWN, 2);
    chk(nNeg, 32'h1);
    fork
      k(KEY_UP, 40);
      #152 chk(jogRunPos, 1'h1);
    join
    $display("jog test done");
    k(KEY_ESCAPE, 2);
    k(KEY_UP, 2);
    k(KEY_SELECT, 2);
    k(KEY_UP, 2);
    k(KEY_SELECT, 2);
    chk(positionDataNumber, 8'h1);
    chk(homeSpeed, 32'(HOME_SPEED_RST));
    alarmActive <= 1'h1;
    k(KEY_SELECT, 2);
    chk(displayCode, DISP_ERROR);
    chk(nStart, 32'h1);
    alarmActive <= 1'h0;
    k(KEY_ESCAPE, 2);
    serialBusy <= 1'h1;
    k(KEY_SELECT, 2);
    chk(displayCode, DISP_MEM_BUSY);
    serialBusy <= 1'h0;
    s = $urandom;
    wr(REG_PRESET_POS, s);
    repeat (2) k(KEY_UP, 2);
    repeat (2) k(KEY_SELECT, 2);
    chk(commandPosition, s);
    k(KEY_ESCAPE, 2);
    wr(REG_CTRL, 32'h3);
    k(KEY_SELECT, 2);
    chk(displayCode, DISP_LOCK_ERR);
    chk(motionInputsGated, motionInputs);
    chk(ioOutputPins, ioOutputNormal);
    wr(REG_CTRL, 32'h2);
    reachedPosition <= ~s;
    k(KEY_UP, 2);
    repeat (2) k(KEY_SELECT, 2);
    chk(teachPosition, ~s);
    chk(teachDataNumber, 8'h1);
    chk(nTeach, 32'h1);
    $display("command test done");
    operatorPermitInput <= 1'h0;
    repeat (6) @(posedge clk_sys);
    chk(testState, PTM_OFF);
    s = $urandom;
    {networkInput, alarmActive, warningActive, readyStatus, motorRunning, posCompleteStatus, serialBusy} <= s[21:0];
    foreach (codes[i])
    begin
      wr(REG_OUT_CODE_BASE, 32'(codes[i]));
      repeat (3) @(posedge clk_sys);
      chk(networkOutput[0], i == 0 ? 1'h0 : s[6-i]);
    end
    wr(REG_OUT_CODE_BASE, 32'h30);
    repeat (3) @(posedge clk_sys);
    chk(networkOutput[0], s[6]);
    $display("network test done");
    giveVerdict();
  end
endmodule : panel_test_mode_and_io_mapping_test
`default_nettype wire
